// file: design/ir_carrier_timer_pair.sv
/*
 8-bit and 16-bit down-counter pair for infrared carrier transmit and
 pulse-width demodulation, with a classic Wishbone register slave.
 assumes input pins are asynchronous and software keeps its own
 sequencing duties.
*/
`timescale 1ns/1ps
`include "ir_timer_map.svh"

module ir_carrier_timer_pair (
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire ir_timer_pkg::addr_t wb_adr_i,
   input  wire ir_timer_pkg::sel_t  wb_sel_i,
   input  wire ir_timer_pkg::word_t wb_dat_i,
   output      ir_timer_pkg::word_t wb_dat_o,
   output      logic               wb_ack_o,
   input  wire logic               input_pin_a,
   input  wire logic               input_pin_b,
   output      logic               short_output_pin,
   output      logic               long_output_pin,
   output      logic               combined_output_pin,
   output      logic               short_irq,
   output      logic               long_irq
);
   import ir_timer_pkg::*;

   state_s     r;
   state_s     n;
   logic       demod;
   logic       pp;
   logic       t8;
   logic       t16;
   logic       rise;
   logic       fall;
   logic       edge_hit;
   logic       term8;
   logic       term16;
   logic       tout8_dm;
   logic       out16;
   logic       pin;
   logic       acc;
   logic       wr;
   logic [3:0] gl;
   logic [7:0] d;

   function automatic logic tick_of(input logic [2:0] dv,
                                    input logic [1:0] f);
      case (f)
         2'b00:   tick_of = 1'b1;
         2'b01:   tick_of = (dv[0] == 1'b0);
         2'b10:   tick_of = (dv[1:0] == 2'b00);
         default: tick_of = (dv == 3'b000);
      endcase
   endfunction

   function automatic logic [7:0] w1c_ctrl(input logic [7:0] old,
                                           input logic [7:0] wd);
      w1c_ctrl = {wd[7:6], old[`B_TOUT] & ~wd[`B_TOUT], wd[4:0]};
   endfunction

   always_comb begin
      n = r;
      n.ack = 1'b0;
      n.irq8 = 1'b0;
      n.irq16 = 1'b0;
      n.div = r.div + 3'h1;
      n.sa = {r.sa[0], input_pin_a};
      n.sb = {r.sb[0], input_pin_b};
      demod = r.c1[`B_DEMOD];
      pp = ~demod & (r.c1[3:2] == 2'b01);
      t8 = tick_of(r.div, r.c0[4:3]);
      t16 = tick_of(r.div, r.c2[4:3]);
      term8 = 1'b0;
      term16 = 1'b0;
      tout8_dm = 1'b0;
      d = wb_dat_i[7:0];

      pin = r.c1[`B_SEL] ? r.sb[1] : r.sa[1];
      case (r.c1[3:2])
         2'b00:   gl = 4'h0;
         2'b01:   gl = `GLITCH_1;
         2'b10:   gl = `GLITCH_2;
         default: gl = `GLITCH_3;
      endcase
      if (!demod) gl = 4'h0;
      if (pin == r.filt) begin
         n.gcnt = 4'h0;
      end else if (r.gcnt >= gl) begin
         n.filt = pin;
         n.gcnt = 4'h0;
      end else begin
         n.gcnt = r.gcnt + 4'h1;
      end
      n.filt_d = r.filt;
      rise = demod & r.filt & ~r.filt_d & r.c1[4];
      fall = demod & ~r.filt & r.filt_d & r.c1[5];
      edge_hit = rise | fall;

      // bus slave: one wait state, unmapped reads zero
      acc = wb_cyc_i & wb_stb_i & ~r.ack;
      wr = acc & wb_we_i & wb_sel_i[0];
      n.ack = acc;
      case (wb_adr_i)
         `OFS_SHORT_CTRL:  n.rdat = r.c0;
         `OFS_SHARED_CTRL: n.rdat = r.c1;
         `OFS_LONG_CTRL:   n.rdat = r.c2;
         `OFS_SHORT_HIGH:  n.rdat = r.th;
         `OFS_SHORT_LOW:   n.rdat = r.tl;
         `OFS_LONG_UPPER:  n.rdat = r.tu;
         `OFS_LONG_LOWER:  n.rdat = r.tlo;
         `OFS_CAP_RISE:    n.rdat = r.cr;
         `OFS_CAP_FALL:    n.rdat = r.cf;
         `OFS_CAP_UPPER:   n.rdat = r.cu;
         `OFS_CAP_LOWER:   n.rdat = r.cl;
         default:          n.rdat = 8'h00;
      endcase
      if (wr) begin
         case (wb_adr_i)
            `OFS_SHORT_CTRL: n.c0 = w1c_ctrl(r.c0, d);
            // edge flags clear by writing one
            `OFS_SHARED_CTRL: n.c1 = demod ?
               {d[7:2], r.c1[1:0] & ~d[1:0]} : d;
            `OFS_LONG_CTRL:  n.c2 = w1c_ctrl(r.c2, d);
            `OFS_SHORT_HIGH: n.th = d;
            `OFS_SHORT_LOW:  n.tl = d;
            `OFS_LONG_UPPER: n.tu = d;
            `OFS_LONG_LOWER: n.tlo = d;
            default: ;
         endcase
      end

      // short counter
      if (!r.c0[`B_EN]) begin
         n.st8 = ST_IDLE;
         if (!demod) n.o8 = ~r.c1[`B_RISE];
      end else begin
         case (r.st8)
            ST_IDLE: begin
               n.ph8 = 1'b0;
               if (demod) begin
                  n.c8 = `ALL8;
                  n.st8 = ST_WAIT;
               end else begin
                  n.o8 = r.c1[`B_RISE];
                  n.c8 = r.c1[`B_RISE] ? r.th : r.tl;
                  n.st8 = ST_RUN;
               end
            end
            ST_WAIT: begin
               if (edge_hit) n.st8 = ST_RUN;
            end
            ST_RUN: begin
               if (edge_hit) begin
                  if (rise) begin
                     n.cr = ~r.c8;
                     n.c1[`B_RISE] = 1'b1;
                  end else begin
                     n.cf = ~r.c8;
                     n.c1[`B_FALL] = 1'b1;
                  end
                  n.irq8 = r.c0[`B_CAPM];
                  n.c8 = `ALL8;
               end else if (t8) begin
                  // zero wraps to all ones, no timeout
                  if (r.c8 == 8'h01) term8 = 1'b1;
                  else n.c8 = r.c8 - 8'h01;
               end
            end
            default: n.st8 = ST_IDLE;
         endcase
      end
      if (term8) begin
         if (demod) begin
            n.c8 = 8'h00;
            n.c0[`B_TOUT] = 1'b1;
            n.irq8 = r.c0[`B_TOM];
            tout8_dm = 1'b1;
         end else begin
            n.o8 = ~r.o8;
            n.c8 = r.o8 ? r.tl : r.th;
            if (r.c0[`B_SINGLE]) begin
               n.c8 = 8'h00;
               n.c0[`B_EN] = 1'b0;
               n.c0[`B_TOUT] = 1'b1;
               n.irq8 = r.c0[`B_TOM];
               if (pp) n.c2[`B_EN] = 1'b1;
            end else begin
               n.ph8 = ~r.ph8;
               if (r.ph8) begin
                  n.c0[`B_TOUT] = 1'b1;
                  n.irq8 = r.c0[`B_TOM];
               end
            end
         end
      end

      // long counter
      n.ign_d = r.c2[`B_SINGLE];
      if (!r.c2[`B_EN]) begin
         n.st16 = ST_IDLE;
         if (!demod) n.o16 = ~r.c1[`B_FALL];
      end else begin
         case (r.st16)
            ST_IDLE: begin
               if (demod) begin
                  n.st16 = ST_WAIT;
               end else begin
                  n.o16 = r.c1[`B_FALL];
                  n.c16 = {r.tu, r.tlo};
                  n.st16 = ST_RUN;
               end
            end
            ST_WAIT: begin
               if (edge_hit) begin
                  {n.cu, n.cl} = ~r.c16;
                  n.c16 = {r.tu, r.tlo};
                  n.st16 = ST_RUN;
               end
            end
            ST_RUN: begin
               if (edge_hit && !r.c2[`B_SINGLE]) begin
                  {n.cu, n.cl} = ~r.c16;
                  if (rise) n.c1[`B_RISE] = 1'b1;
                  else n.c1[`B_FALL] = 1'b1;
                  n.irq16 = r.c2[`B_CAPM];
                  n.c16 = `ALL16;
               end else begin
                  if (demod && r.c2[`B_SINGLE] && tout8_dm) begin
                     {n.cu, n.cl} = ~r.c16;
                     n.irq16 = r.c2[`B_CAPM];
                  end
                  if (t16) begin
                     if (r.c16 == 16'h0001) term16 = 1'b1;
                     else n.c16 = r.c16 - 16'h0001;
                  end
               end
               if (demod && r.c2[`B_SINGLE] && !r.ign_d) n.st16 = ST_WAIT;
            end
            default: n.st16 = ST_IDLE;
         endcase
      end
      if (term16) begin
         n.c16 = 16'h0000;
         n.c2[`B_TOUT] = 1'b1;
         n.irq16 = r.c2[`B_TOM];
         if (!demod) begin
            n.o16 = ~r.o16;
            if (r.c2[`B_SINGLE]) begin
               n.c2[`B_EN] = 1'b0;
               if (pp) n.c0[`B_EN] = 1'b1;
            end else begin
               n.c16 = {r.tu, r.tlo};
            end
         end
      end

      out16 = (!demod && r.c1[3]) ? r.c1[2] : r.o16;
      n.p34 = r.c0[`B_PIN] & r.o8;
      n.p35 = r.c2[`B_PIN] & out16;
      case (r.c1[5:4])
         2'b00:   n.p36 = r.o8 & out16;
         2'b01:   n.p36 = r.o8 | out16;
         2'b10:   n.p36 = ~(r.o8 | out16);
         default: n.p36 = ~(r.o8 & out16);
      endcase
      n.p36 = n.p36 & ~demod & r.c1[`B_SEL];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.st8 <= ST_IDLE;
         r.st16 <= ST_IDLE;
         r.c0 <= `CTRL_RESET;
         r.c1 <= `CTRL_RESET;
         r.c2 <= `CTRL_RESET;
         r.th <= `RELOAD_RESET;
         r.tl <= `RELOAD_RESET;
         r.tu <= `RELOAD_RESET;
         r.tlo <= `RELOAD_RESET;
      end else begin
         r <= n;
      end
   end

   assign wb_dat_o = {24'h000000, r.rdat};
   assign wb_ack_o = r.ack;
   assign short_output_pin = r.p34;
   assign long_output_pin = r.p35;
   assign combined_output_pin = r.p36;
   assign short_irq = r.irq8;
   assign long_irq = r.irq16;

   glitch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (r.c1[7] && r.c1[3:2] == 2'b11 && r.gcnt < 4'hf)
      |=> r.filt == $past(r.filt))
      else $error("filter output changed too early");

   idle_short_a: assert property (@(posedge clk) disable iff (!resetn)
      (!r.c0[7] && !r.c1[7] && $past(resetn)) |=> r.o8 == !$past(r.c1[1]))
      else $error("short idle level wrong");

   load_short_a: assert property (@(posedge clk) disable iff (!resetn)
      (r.c0[7] && r.st8 == ST_IDLE && !r.c1[7])
      |=> (r.st8 == ST_RUN && r.o8 == $past(r.c1[1]) &&
           r.c8 == ($past(r.c1[1]) ? $past(r.th) : $past(r.tl))))
      else $error("short load wrong");

   single_stop_a: assert property (@(posedge clk) disable iff (!resetn)
      (r.st8 == ST_RUN && r.c0[7] && r.c0[6] && !r.c1[7] && !edge_hit &&
       t8 && r.c8 == 8'h01)
      |=> (!r.c0[7] && r.c0[5] && r.o8 != $past(r.o8) &&
           short_irq == $past(r.c0[1])) ##1 r.st8 == ST_IDLE)
      else $error("single pass end wrong");

   wrap_short_a: assert property (@(posedge clk) disable iff (!resetn)
      (r.st8 == ST_RUN && r.c0[7] && !edge_hit && t8 && r.c8 == 8'h00)
      |=> r.c8 == 8'hff)
      else $error("short wrap from zero wrong");

   cap_short_a: assert property (@(posedge clk) disable iff (!resetn)
      (r.st8 == ST_RUN && r.c0[7] && rise)
      |=> (r.cr == ~$past(r.c8) && r.c1[1] && r.c8 == 8'hff))
      else $error("short rise capture wrong");

   force_long_a: assert property (@(posedge clk) disable iff (!resetn)
      (!r.c1[7] && r.c1[3] && r.c2[0]) |=> long_output_pin == $past(r.c1[2]))
      else $error("long forced level wrong");

   swap_pp_a: assert property (@(posedge clk) disable iff (!resetn)
      (term16 && pp && r.c2[6]) |=> (r.c0[7] && !r.c2[7]) ##1 r.st8 == ST_RUN)
      else $error("alternating hand-over wrong");

   comb_and_a: assert property (@(posedge clk) disable iff (!resetn)
      (!r.c1[7] && r.c1[6] && r.c1[5:4] == 2'b00)
      |=> combined_output_pin == ($past(r.o8) & $past(out16)))
      else $error("combined output wrong");

   ack_once_a: assert property (@(posedge clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule

// file: design/ir_timer_map.svh
/*
 offsets, field positions, reset values and fixed counts of the
 infrared carrier timer pair; assumes a 32-bit classic Wishbone bus
 with byte addresses, one register per aligned word.
*/
`ifndef IR_TIMER_MAP_SVH
`define IR_TIMER_MAP_SVH

`define OFS_SHORT_CTRL   6'h00
`define OFS_SHARED_CTRL  6'h04
`define OFS_LONG_CTRL    6'h08
`define OFS_SHORT_HIGH   6'h0c
`define OFS_SHORT_LOW    6'h10
`define OFS_LONG_UPPER   6'h14
`define OFS_LONG_LOWER   6'h18
`define OFS_CAP_RISE     6'h1c
`define OFS_CAP_FALL     6'h20
`define OFS_CAP_UPPER    6'h24
`define OFS_CAP_LOWER    6'h28

// short and long control
`define B_EN     7
`define B_SINGLE 6
`define B_TOUT   5
`define B_CAPM   2
`define B_TOM    1
`define B_PIN    0
// shared control
`define B_DEMOD  7
`define B_SEL    6
`define B_RISE   1
`define B_FALL   0

`define CTRL_RESET   8'h00
`define RELOAD_RESET 8'h00
`define ALL8         8'hff
`define ALL16        16'hffff

// extra cycles an input must stay stable, per glitch field value
`define GLITCH_1     4'h3
`define GLITCH_2     4'h7
`define GLITCH_3     4'hf

`endif

// file: design/ir_timer_pkg.sv
/*
 types of the infrared carrier timer pair; assumes nothing beyond
 a SystemVerilog compiler.
*/
package ir_timer_pkg;

   typedef logic [31:0] word_t;
   typedef logic [5:0]  addr_t;
   typedef logic [3:0]  sel_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } cnt_state_e;

   typedef struct packed {
      logic [7:0]  c0;
      logic [7:0]  c1;
      logic [7:0]  c2;
      logic [7:0]  th;
      logic [7:0]  tl;
      logic [7:0]  tu;
      logic [7:0]  tlo;
      logic [7:0]  cr;
      logic [7:0]  cf;
      logic [7:0]  cu;
      logic [7:0]  cl;
      logic [7:0]  c8;
      logic [15:0] c16;
      cnt_state_e  st8;
      cnt_state_e  st16;
      logic        ph8;
      logic        o8;
      logic        o16;
      logic        ign_d;
      logic [2:0]  div;
      logic [1:0]  sa;
      logic [1:0]  sb;
      logic        filt;
      logic        filt_d;
      logic [3:0]  gcnt;
      logic        ack;
      logic [7:0]  rdat;
      logic        irq8;
      logic        irq16;
      logic        p34;
      logic        p35;
      logic        p36;
   } state_s;

endpackage

// file: tb/ir_carrier_timer_pair_tb_top.sv
/*
 register-level bench of the infrared timer pair. assumes classic
 Wishbone with one-cycle ack and the map of ir_timer_map.svh.
*/
`timescale 1ns/1ps
`include "ir_timer_map.svh"

module ir_carrier_timer_pair_tb_top;
   import ir_timer_pkg::*;
   logic  clk = 1'b0;
   logic  resetn = 1'b0;
   logic  wb_cyc_i = 1'b0;
   logic  wb_stb_i = 1'b0;
   logic  wb_we_i = 1'b0;
   addr_t wb_adr_i = '0;
   sel_t  wb_sel_i = '0;
   word_t wb_dat_i = '0;
   word_t wb_dat_o;
   logic  wb_ack_o, input_pin_a, input_pin_b, short_irq, long_irq;
   logic  short_output_pin, long_output_pin, combined_output_pin;
   int    err_total = 0;
   int    comparisons = 0;
   int    n, t0;
   logic [7:0] q;

   always #50 clk = ~clk;

   ir_carrier_timer_pair i_dut (.clk(clk), .resetn(resetn),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .input_pin_a(input_pin_a), .input_pin_b(input_pin_b),
      .short_output_pin(short_output_pin),
      .long_output_pin(long_output_pin),
      .combined_output_pin(combined_output_pin),
      .short_irq(short_irq), .long_irq(long_irq));

   ir_signal_source i_partner (.clk(clk),
      .short_output_pin(short_output_pin),
      .long_output_pin(long_output_pin),
      .input_pin_a(input_pin_a), .input_pin_b(input_pin_b));

   task automatic give_verdict;
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string m);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h wanted %h", $time, m,
                  seen, exp);
      end
   endtask

   task automatic in_range(input int v, input int lo, input int hi,
                           input string m);
      check(32'(v >= lo && v <= hi), 32'h1, m);
   endtask

   task automatic wb_io(input addr_t a, input logic we, input logic [7:0] d,
                        input sel_t s, output logic [7:0] r);
      int k;
      k = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      // ack and read data are taken at the rising edge that shows ack
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (wb_ack_o !== 1'b1) begin
         err_total++;
         give_verdict();
      end
      r = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wr(input addr_t a, input logic [7:0] d);
      logic [7:0] r;
      wb_io(a, 1'b1, d, 4'hf, r);
   endtask

   task automatic rd_chk(input addr_t a, input logic [7:0] e, input string m);
      logic [7:0] r;
      wb_io(a, 1'b0, 8'h00, 4'hf, r);
      check(r, e, m);
   endtask

   task automatic wait_irq(input logic lng, output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while ((lng ? long_irq : short_irq) !== 1'b1 && c < 2000);
      if (c >= 2000) begin
         err_total++;
         give_verdict();
      end
   endtask

   function automatic logic comb(input int f, input logic a, input logic b);
      case (f)
         0: return a & b;
         1: return a | b;
         2: return ~(a | b);
         default: return ~(a & b);
      endcase
   endfunction

   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rd_chk(addr_t'(i * 4), 8'h00, "reset or unmapped read");
      wr(`OFS_SHORT_HIGH, 8'ha5);
      rd_chk(`OFS_SHORT_HIGH, 8'ha5, "reload readback");
      wb_io(`OFS_SHORT_LOW, 1'b1, 8'h5a, 4'he, q);
      rd_chk(`OFS_SHORT_LOW, 8'h00, "write without sel0");
      wr(`OFS_CAP_RISE, 8'hff);
      rd_chk(`OFS_CAP_RISE, 8'h00, "capture is read only");
      wr(`OFS_SHORT_CTRL, 8'h01);
      wr(`OFS_LONG_CTRL, 8'h01);
      for (int f = 0; f < 4; f++)
         for (int l = 0; l < 4; l++) begin
            wr(`OFS_SHARED_CTRL, {2'b01, f[1:0], 2'b00, l[1:0]});
            repeat (4) @(negedge clk);
            check(short_output_pin, !l[1], "short idle");
            check(long_output_pin, !l[0], "long idle");
            check(combined_output_pin, comb(f, ~l[1], ~l[0]), "comb");
         end
      for (int i = 2; i < 4; i++) begin
         wr(`OFS_SHARED_CTRL, {4'b0100, i[1:0], {2{i[0]}}});
         repeat (4) @(negedge clk);
         check(long_output_pin, i[0], "forced long level");
      end
      wr(`OFS_SHARED_CTRL, 8'h00);
      wr(`OFS_SHORT_LOW, 8'd20);
      wr(`OFS_SHORT_CTRL, 8'hc3);
      repeat (6) @(negedge clk);
      check(short_output_pin, 1'b0, "initial level on enable");
      wait_irq(1'b0, n);
      in_range(n, 12, 17, "single pass length");
      repeat (3) @(negedge clk);
      check(short_output_pin, 1'b1, "toggle at terminal");
      rd_chk(`OFS_SHORT_CTRL, 8'h63, "stopped and flagged");
      wr(`OFS_SHORT_CTRL, 8'h63);
      rd_chk(`OFS_SHORT_CTRL, 8'h43, "flag cleared");
      wr(`OFS_SHORT_LOW, 8'h00);
      wr(`OFS_SHORT_CTRL, 8'hc3);
      wait_irq(1'b0, n);
      in_range(n, 254, 260, "zero count wraps");
      wr(`OFS_SHORT_CTRL, 8'h23);
      wr(`OFS_SHORT_HIGH, 8'd10);
      wr(`OFS_SHORT_LOW, 8'd10);
      t0 = i_partner.toggles;
      wr(`OFS_SHORT_CTRL, 8'h83);
      wait_irq(1'b0, n);
      in_range(n, 19, 26, "modulo irq on second terminal");
      repeat (3) @(negedge clk);
      check(i_partner.toggles - t0, 3, "modulo toggles");
      wr(`OFS_SHORT_CTRL, 8'h03);
      wr(`OFS_SHORT_CTRL, 8'h23);
      rd_chk(`OFS_SHORT_CTRL, 8'h03, "stop then clear");
      wr(`OFS_LONG_UPPER, 8'h01);
      wr(`OFS_LONG_LOWER, 8'h02);
      t0 = i_partner.long_toggles;
      wr(`OFS_LONG_CTRL, 8'hc3);
      wait_irq(1'b1, n);
      in_range(n, 256, 262, "long count upper*256+lower");
      rd_chk(`OFS_LONG_CTRL, 8'h63, "long stopped and flagged");
      check(i_partner.long_toggles - t0, 2, "long pin toggles");
      wr(`OFS_LONG_CTRL, 8'h20);
      wr(`OFS_SHORT_LOW, 8'd5);
      wr(`OFS_LONG_LOWER, 8'h00);
      wr(`OFS_SHORT_CTRL, 8'h40);
      wr(`OFS_LONG_CTRL, 8'h40);
      wr(`OFS_SHARED_CTRL, 8'h04);
      wr(`OFS_SHORT_CTRL, 8'hc0);
      repeat (20) @(negedge clk);
      rd_chk(`OFS_SHORT_CTRL, 8'h60, "short handed over");
      rd_chk(`OFS_LONG_CTRL, 8'hc0, "long started");
      // long runs 256 cycles, hands back, short hands over again
      repeat (270) @(negedge clk);
      rd_chk(`OFS_LONG_CTRL, 8'he0, "long enabled again, flagged");
      rd_chk(`OFS_SHORT_CTRL, 8'h60, "short stopped again");
      wr(`OFS_SHARED_CTRL, 8'h00);
      wr(`OFS_LONG_CTRL, 8'h00);
      wr(`OFS_LONG_CTRL, 8'h20);
      wr(`OFS_SHORT_CTRL, 8'h20);
      wr(`OFS_SHORT_HIGH, 8'hff);
      wr(`OFS_SHORT_LOW, 8'hff);
      wr(`OFS_SHARED_CTRL, 8'hb0);
      wr(`OFS_SHORT_CTRL, 8'h84);
      i_partner.drive_level(1'b1, 39);
      i_partner.drive_level(1'b0, 29);
      i_partner.drive_level(1'b1, 10);
      wb_io(`OFS_CAP_FALL, 1'b0, 8'h00, 4'hf, q);
      in_range(q, 36, 44, "fall capture");
      wb_io(`OFS_CAP_RISE, 1'b0, 8'h00, 4'hf, q);
      in_range(q, 26, 34, "rise capture");
      rd_chk(`OFS_SHARED_CTRL, 8'hb3, "edge flags set");
      wr(`OFS_SHARED_CTRL, 8'hb3);
      rd_chk(`OFS_SHARED_CTRL, 8'hb0, "edge flags cleared");
      wr(`OFS_SHARED_CTRL, 8'hb4);
      i_partner.drive_level(1'b0, 1);
      i_partner.drive_level(1'b1, 20);
      rd_chk(`OFS_SHARED_CTRL, 8'hb4, "glitch dropped");
      i_partner.drive_level(1'b0, 20);
      rd_chk(`OFS_SHARED_CTRL, 8'hb5, "wide pulse passes");
      wr(`OFS_SHORT_CTRL, 8'h00);
      // long reloads all ones before demodulation
      wr(`OFS_LONG_UPPER, 8'hff);
      wr(`OFS_LONG_LOWER, 8'hff);
      wr(`OFS_SHARED_CTRL, 8'hb1);
      wr(`OFS_LONG_CTRL, 8'h84);
      i_partner.drive_level(1'b1, 29);
      i_partner.drive_level(1'b0, 20);
      rd_chk(`OFS_CAP_UPPER, 8'h00, "long capture upper");
      wb_io(`OFS_CAP_LOWER, 1'b0, 8'h00, 4'hf, q);
      in_range(q, 26, 34, "long capture lower");
      rd_chk(`OFS_SHARED_CTRL, 8'hb1, "long fall flag");
      wr(`OFS_LONG_CTRL, 8'h00);
      give_verdict();
   end

   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule

// file: tb/ir_signal_source.sv
/*
 far side of the timer pair: an infrared receiver driving the two
 input pins and a load watching the short and long transmit pins. assumes the bench
 calls drive_level to shape pulses on the selected input.
*/
`timescale 1ns/1ps

module ir_signal_source (
   input  wire logic clk,
   input  wire logic short_output_pin,
   input  wire logic long_output_pin,
   output logic      input_pin_a,
   output logic      input_pin_b
);
   int   toggles;
   int   long_toggles;
   logic last_s;
   logic last_l;

   initial begin
      input_pin_a = 1'b0;
      input_pin_b = 1'b0;
      toggles = 0;
      long_toggles = 0;
      last_s = 1'b0;
      last_l = 1'b0;
   end

   // unselected input keeps moving so a wrong select is seen
   always @(posedge clk) begin
      input_pin_b <= ~input_pin_b;
      if (short_output_pin !== last_s)
         toggles++;
      if (long_output_pin !== last_l)
         long_toggles++;
      last_s = short_output_pin;
      last_l = long_output_pin;
   end

   // new level, then hold it for the given number of cycles
   task automatic drive_level(input logic v, input int hold);
      @(posedge clk);
      input_pin_a <= v;
      repeat (hold) @(posedge clk);
   endtask
endmodule
